/* File: bsp_pkg.sv */
// package for the boundary-scan test port: instruction codes, tap states
package bsp_pkg;

  // ---------------------------------------------------------------
  // sizes and capture values
  // ---------------------------------------------------------------
  localparam int BSP_IR_LEN = 10;
  localparam int BSP_ID_LEN = 32;
  localparam int BSP_CFG_BITS = 8;
  localparam int BSP_CELLS_PER_PIN = 3;
  localparam logic [BSP_IR_LEN-1:0] BSP_IR_CAPTURE = 10'h001;
  localparam logic [2:0] BSP_CFG_LAST = 3'h7;

  // ---------------------------------------------------------------
  // instruction codes
  // ---------------------------------------------------------------
  localparam logic [BSP_IR_LEN-1:0] BSP_INS_EXTEST = 10'h000;
  localparam logic [BSP_IR_LEN-1:0] BSP_INS_CFG_LOAD = 10'h002;
  localparam logic [BSP_IR_LEN-1:0] BSP_INS_SAMPLE = 10'h005;
  localparam logic [BSP_IR_LEN-1:0] BSP_INS_IDENT = 10'h006;
  localparam logic [BSP_IR_LEN-1:0] BSP_INS_USER = 10'h007;
  localparam logic [BSP_IR_LEN-1:0] BSP_INS_CLAMP = 10'h00A;
  localparam logic [BSP_IR_LEN-1:0] BSP_INS_HIGHZ = 10'h00B;
  localparam logic [BSP_IR_LEN-1:0] BSP_INS_LA_ARM = 10'h00E;
  localparam logic [BSP_IR_LEN-1:0] BSP_INS_LA_READ = 10'h00F;
  localparam logic [BSP_IR_LEN-1:0] BSP_INS_BYPASS = 10'h3FF;

  // ---------------------------------------------------------------
  // tap controller states
  // ---------------------------------------------------------------
  typedef enum logic [15:0] {
    BSP_RESET = 16'h0001, BSP_IDLE = 16'h0002,
    BSP_SEL_DR = 16'h0004, BSP_CAP_DR = 16'h0008,
    BSP_SH_DR = 16'h0010, BSP_EX1_DR = 16'h0020,
    BSP_PA_DR = 16'h0040, BSP_EX2_DR = 16'h0080,
    BSP_UPD_DR = 16'h0100, BSP_SEL_IR = 16'h0200,
    BSP_CAP_IR = 16'h0400, BSP_SH_IR = 16'h0800,
    BSP_EX1_IR = 16'h1000, BSP_PA_IR = 16'h2000,
    BSP_EX2_IR = 16'h4000, BSP_UPD_IR = 16'h8000
  } bsp_tap_e;

  // data path and pin modes (test, hz) selected by the current instruction
  typedef struct packed {
    logic bsr;
    logic ident;
    logic user;
    logic cfg;
    logic la_arm;
    logic la_rd;
    logic one;
    logic test;
    logic hz;
  } bsp_sel_s;

  function automatic bsp_tap_e bsp_tap_next(bsp_tap_e s, logic tms);
    unique case (s)
      BSP_RESET: bsp_tap_next = tms ? BSP_RESET : BSP_IDLE;
      BSP_IDLE: bsp_tap_next = tms ? BSP_SEL_DR : BSP_IDLE;
      BSP_SEL_DR: bsp_tap_next = tms ? BSP_SEL_IR : BSP_CAP_DR;
      BSP_CAP_DR: bsp_tap_next = tms ? BSP_EX1_DR : BSP_SH_DR;
      BSP_SH_DR: bsp_tap_next = tms ? BSP_EX1_DR : BSP_SH_DR;
      BSP_EX1_DR: bsp_tap_next = tms ? BSP_UPD_DR : BSP_PA_DR;
      BSP_PA_DR: bsp_tap_next = tms ? BSP_EX2_DR : BSP_PA_DR;
      BSP_EX2_DR: bsp_tap_next = tms ? BSP_UPD_DR : BSP_SH_DR;
      BSP_UPD_DR: bsp_tap_next = tms ? BSP_SEL_DR : BSP_IDLE;
      BSP_SEL_IR: bsp_tap_next = tms ? BSP_RESET : BSP_CAP_IR;
      BSP_CAP_IR: bsp_tap_next = tms ? BSP_EX1_IR : BSP_SH_IR;
      BSP_SH_IR: bsp_tap_next = tms ? BSP_EX1_IR : BSP_SH_IR;
      BSP_EX1_IR: bsp_tap_next = tms ? BSP_UPD_IR : BSP_PA_IR;
      BSP_PA_IR: bsp_tap_next = tms ? BSP_EX2_IR : BSP_PA_IR;
      BSP_EX2_IR: bsp_tap_next = tms ? BSP_UPD_IR : BSP_SH_IR;
      BSP_UPD_IR: bsp_tap_next = tms ? BSP_SEL_DR : BSP_IDLE;
      default: bsp_tap_next = BSP_RESET;
    endcase
  endfunction

  // unassigned codes fall through to the single bypass stage
  function automatic bsp_sel_s bsp_decode(logic [BSP_IR_LEN-1:0] ir);
    bsp_sel_s d;
    d = '0;
    case (ir)
      BSP_INS_SAMPLE: d.bsr = 1'b1;
      BSP_INS_EXTEST: begin
        d.bsr = 1'b1;
        d.test = 1'b1;
      end
      BSP_INS_IDENT: d.ident = 1'b1;
      BSP_INS_USER: d.user = 1'b1;
      BSP_INS_CFG_LOAD: d.cfg = 1'b1;
      BSP_INS_LA_ARM: d.la_arm = 1'b1;
      BSP_INS_LA_READ: d.la_rd = 1'b1;
      BSP_INS_CLAMP: begin
        d.one = 1'b1;
        d.test = 1'b1;
      end
      BSP_INS_HIGHZ: begin
        d.one = 1'b1;
        d.hz = 1'b1;
      end
      default: d.one = 1'b1;
    endcase
    return d;
  endfunction

endpackage

/* File: bsp_scan_host.sv */
// scan host model: drives the link, clock runs only within frames
module bsp_scan_host (
  // link
  output logic scan_clk,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scan_clk = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // change while low, sample serial out at the rise
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #62.5 scan_clk = 1'b1;
    o = tdo;
    #62.5 scan_clk = 1'b0;
  endtask

  task automatic run_tlr(input int n);
    logic o;
    repeat (n) tick(1'b1, 1'b0, o);
  endtask

  // idle to shift, n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
    output logic [63:0] dout);
    logic o;
    dout = '0;
    tick(1'b0, 1'b0, o);
    tick(1'b1, 1'b0, o);
    if (ir) tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o);
    for (int k = 0; k < n; k++) begin
      tick(k == n - 1, din[k], o);
      dout[k] = o;
    end
    tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
    // released data line must not look like a held value
    tdi = ~din[n-1];
  endtask
endmodule

/* File: bsp_test_port.sv */
// boundary-scan test access port with config path and trace analyzer

module bsp_test_port
  import bsp_pkg::*;
#(
  parameter int BSR_LEN = 1524,
  parameter int LA_W = 16,
  parameter int LA_DEPTH = 64,
  parameter logic [3:0] ID_VERSION = 4'h1,        // arbitrary value
  parameter logic [15:0] ID_PART = 16'h5A3C,      // arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h2B5,      // arbitrary value
  parameter logic [31:0] USER_CODE = 32'hFFFFFFFF
) (
  // core clock and reset
  input wire logic clk,
  input wire logic rst,
  // scan link
  input wire logic scan_clk,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // user i/o pins and the core behind them
  input wire logic [BSR_LEN/3-1:0] pin_in,
  input wire logic [BSR_LEN/3-1:0] core_out,
  input wire logic [BSR_LEN/3-1:0] core_oe,
  input wire logic [BSR_LEN/3-1:0] keep_en,
  output logic [BSR_LEN/3-1:0] pin_out,
  output logic [BSR_LEN/3-1:0] pin_oe,
  output logic [BSR_LEN/3-1:0] pin_keep,
  // configuration path
  input wire logic cfg_busy,
  output logic [BSP_CFG_BITS-1:0] cfg_data,
  output logic cfg_valid,
  // embedded analyzer
  input wire logic [LA_W-1:0] probe,
  output logic la_done
);

  localparam int NPIN = BSR_LEN / BSP_CELLS_PER_PIN;
  localparam int AW = $clog2(LA_DEPTH);
  localparam logic [AW-1:0] LA_LAST = AW'(LA_DEPTH - 1);
  localparam logic [BSP_ID_LEN-1:0] ID_WORD =
    {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  // ---------------------------------------------------------------
  // scan clock domain state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rsync;
    logic [1:0] done_s;
    bsp_tap_e st;
    logic [BSP_IR_LEN-1:0] ir;
    logic [BSP_IR_LEN-1:0] ir_sh;
    logic m_test;
    logic m_hz;
    logic byp;
    logic [BSP_ID_LEN-1:0] w32;
    logic [BSR_LEN-1:0] smp1;
    logic [BSR_LEN-1:0] smp2;
    logic [BSR_LEN-1:0] bsr_sh;
    logic [BSR_LEN-1:0] bsr_upd;
    logic [LA_W:0] la_sh;
    logic [BSP_CFG_BITS-1:0] cfg_sh;
    logic [BSP_CFG_BITS-1:0] cfg_hold;
    logic [2:0] cfg_cnt;
    logic cfg_tog;
    logic upd_tog;
    logic arm_tog;
    logic rd_tog;
  } bsp_scan_s;

  typedef struct packed {
    logic tdo;
    logic oe;
  } bsp_out_s;

  // ---------------------------------------------------------------
  // core clock domain state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] upd_s;
    logic [2:0] cfg_s;
    logic [2:0] arm_s;
    logic [2:0] rd_s;
    logic [1:0] test_s;
    logic [1:0] hz_s;
    logic [NPIN-1:0] hout;
    logic [NPIN-1:0] hoe;
    logic [NPIN-1:0] pout;
    logic [NPIN-1:0] poe;
    logic [NPIN-1:0] keep;
    logic [BSP_CFG_BITS-1:0] cfg_data;
    logic cfg_valid;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic cap;
    logic done;
    logic [LA_W-1:0] la_word;
  } bsp_core_s;

  bsp_scan_s t_reg, t_next;
  bsp_out_s o_reg, o_next;
  bsp_core_s c_reg, c_next;
  logic [LA_W-1:0] la_mem [LA_DEPTH];
  logic [BSR_LEN-1:0] obs;
  bsp_sel_s sel;
  logic tck_rst;

  // pin observation, three cells per pin: input, output, enable
  for (genvar i = 0; i < NPIN; i++) begin : g_obs
    assign obs[3*i] = pin_in[i];
    assign obs[3*i+1] = c_reg.pout[i];
    assign obs[3*i+2] = c_reg.poe[i];
  end

  // ---------------------------------------------------------------
  // instruction decode and scan-side reset
  // ---------------------------------------------------------------
  // the scan side leaves reset through two scan stages, so the host
  // has to keep its clock running while the core reset is held
  assign sel = bsp_decode(t_reg.ir);
  assign tck_rst = t_reg.rsync[1];

  // ---------------------------------------------------------------
  // tap controller and scan registers
  // ---------------------------------------------------------------
  always_comb begin
    bsp_sel_s nsel;
    nsel = '0;
    t_next = t_reg;
    t_next.rsync = {t_reg.rsync[0], rst};
    // the analyzer's full flag comes from the core clock
    t_next.done_s = {t_reg.done_s[0], c_reg.done};
    // pin levels come from another domain, so two stages before capture
    t_next.smp1 = obs;
    t_next.smp2 = t_reg.smp1;
    t_next.st = bsp_tap_next(t_reg.st, tms);
    unique case (t_reg.st)
      BSP_RESET: t_next.ir = BSP_INS_IDENT;
      BSP_CAP_IR: t_next.ir_sh = BSP_IR_CAPTURE;
      BSP_SH_IR: t_next.ir_sh = {tdi, t_reg.ir_sh[BSP_IR_LEN-1:1]};
      BSP_UPD_IR: t_next.ir = t_reg.ir_sh;
      BSP_CAP_DR: begin
        t_next.byp = 1'b0;
        t_next.cfg_cnt = '0;
        if (sel.ident) begin
          t_next.w32 = ID_WORD;
        end
        if (sel.user) begin
          t_next.w32 = USER_CODE;
        end
        if (sel.bsr) begin
          t_next.bsr_sh = t_reg.smp2;
        end
        if (sel.la_rd) begin
          // word is steady here; the toggle fetches the next one
          t_next.la_sh = {t_reg.done_s[1], c_reg.la_word};
          t_next.rd_tog = ~t_reg.rd_tog;
        end
      end
      BSP_SH_DR: begin
        t_next.byp = tdi;
        t_next.w32 = {tdi, t_reg.w32[BSP_ID_LEN-1:1]};
        t_next.bsr_sh = {tdi, t_reg.bsr_sh[BSR_LEN-1:1]};
        t_next.la_sh = {tdi, t_reg.la_sh[LA_W:1]};
        // a byte cut short by leaving shift is dropped at the next capture
        if (sel.cfg) begin
          t_next.cfg_sh = {tdi, t_reg.cfg_sh[BSP_CFG_BITS-1:1]};
          t_next.cfg_cnt = 3'(t_reg.cfg_cnt + 3'h1);
          if (t_reg.cfg_cnt == BSP_CFG_LAST) begin
            t_next.cfg_hold = {tdi, t_reg.cfg_sh[BSP_CFG_BITS-1:1]};
            t_next.cfg_tog = ~t_reg.cfg_tog;
          end
        end
      end
      BSP_UPD_DR: begin
        // the update stage moves only here, never in the middle of a shift
        if (sel.bsr) begin
          t_next.bsr_upd = t_reg.bsr_sh;
          t_next.upd_tog = ~t_reg.upd_tog;
        end
        if (sel.la_arm) begin
          t_next.arm_tog = ~t_reg.arm_tog;
        end
      end
      BSP_IDLE, BSP_SEL_DR, BSP_EX1_DR, BSP_PA_DR, BSP_EX2_DR,
      BSP_SEL_IR, BSP_EX1_IR, BSP_PA_IR, BSP_EX2_IR: begin
      end
    endcase
    // modes follow the instruction as it is updated, so the pins switch
    // even when the host stops its clock in idle right after update-ir
    nsel = bsp_decode(t_next.ir);
    t_next.m_test = nsel.test;
    t_next.m_hz = nsel.hz;
    // the synchroniser keeps shifting during reset so release is clean
    if (tck_rst) begin
      t_next = '0;
      t_next.rsync = {t_reg.rsync[0], rst};
      t_next.st = BSP_RESET;
      t_next.ir = BSP_INS_IDENT;
    end
  end

  always_ff @(posedge scan_clk) begin
    t_reg <= t_next;
  end

  // serial output changes on the falling edge, as the scan standard asks
  always_comb begin
    o_next = '0;
    if (t_reg.st == BSP_SH_IR) begin
      o_next.tdo = t_reg.ir_sh[0];
      o_next.oe = 1'b1;
    end else if (t_reg.st == BSP_SH_DR) begin
      o_next.oe = 1'b1;
      if (sel.bsr) begin
        o_next.tdo = t_reg.bsr_sh[0];
      end else if (sel.ident || sel.user) begin
        o_next.tdo = t_reg.w32[0];
      end else if (sel.la_rd) begin
        o_next.tdo = t_reg.la_sh[0];
      end else begin
        // bypass also carries config, highz, clamp and unknown codes
        o_next.tdo = t_reg.byp;
      end
    end
    if (tck_rst) begin
      o_next = '0;
    end
  end

  always_ff @(negedge scan_clk) begin
    o_reg <= o_next;
  end

  // ---------------------------------------------------------------
  // core side: pins, configuration bytes, analyzer
  // ---------------------------------------------------------------
  always_comb begin
    logic test;
    logic hz;
    test = 1'b0;
    hz = 1'b0;
    c_next = c_reg;
    c_next.upd_s = {c_reg.upd_s[1:0], t_reg.upd_tog};
    c_next.cfg_s = {c_reg.cfg_s[1:0], t_reg.cfg_tog};
    c_next.arm_s = {c_reg.arm_s[1:0], t_reg.arm_tog};
    c_next.rd_s = {c_reg.rd_s[1:0], t_reg.rd_tog};
    c_next.test_s = {c_reg.test_s[0], t_reg.m_test};
    c_next.hz_s = {c_reg.hz_s[0], t_reg.m_hz};
    c_next.cfg_valid = 1'b0;
    // update stage is steady long after its toggle, safe to copy here
    if (c_reg.upd_s[2] != c_reg.upd_s[1]) begin
      for (int i = 0; i < NPIN; i++) begin
        c_next.hout[i] = t_reg.bsr_upd[3*i+1];
        c_next.hoe[i] = t_reg.bsr_upd[3*i+2];
      end
    end
    // pin test modes stay off while configuration is running
    test = c_reg.test_s[1] && !cfg_busy;
    hz = c_reg.hz_s[1] && !cfg_busy;
    // the keeper is only flagged here; its drive stays in the pad ring
    for (int i = 0; i < NPIN; i++) begin
      c_next.pout[i] = test ? c_reg.hout[i] : core_out[i];
      c_next.poe[i] = hz ? 1'b0 : (test ? c_reg.hoe[i] : core_oe[i]);
      c_next.keep[i] = keep_en[i] && (test || hz) && !c_next.poe[i];
    end
    // the held byte stands for eight scan clocks, far beyond the sync
    if (c_reg.cfg_s[2] != c_reg.cfg_s[1]) begin
      c_next.cfg_data = t_reg.cfg_hold;
      c_next.cfg_valid = 1'b1;
    end
    // trace capture runs every core cycle until the memory is full
    if (c_reg.cap) begin
      c_next.wr = AW'(c_reg.wr + 1'b1);
      if (c_reg.wr == LA_LAST) begin
        c_next.cap = 1'b0;
        c_next.done = 1'b1;
      end
    end
    if (c_reg.rd_s[2] != c_reg.rd_s[1]) begin
      c_next.rd = AW'(c_reg.rd + 1'b1);
    end
    // a new arm restarts the trace and clears the full flag
    if (c_reg.arm_s[2] != c_reg.arm_s[1]) begin
      c_next.wr = '0;
      c_next.rd = '0;
      c_next.cap = 1'b1;
      c_next.done = 1'b0;
    end
    c_next.la_word = la_mem[c_reg.rd];
    if (rst) begin
      c_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    c_reg <= c_next;
  end

  // no reset on the trace memory: only words written since an arm are read
  always_ff @(posedge clk) begin
    if (c_reg.cap) begin
      la_mem[c_reg.wr] <= probe;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // each output is a register of its own domain with nothing behind it
  assign tdo = o_reg.tdo;
  assign tdo_oe = o_reg.oe;
  assign pin_out = c_reg.pout;
  assign pin_oe = c_reg.poe;
  assign pin_keep = c_reg.keep;
  assign cfg_data = c_reg.cfg_data;
  assign cfg_valid = c_reg.cfg_valid;
  assign la_done = c_reg.done;

endmodule

/* File: bsp_test_port_props.sv */
// checker for the boundary-scan test port
module bsp_test_port_props
  import bsp_pkg::*;
#(
  parameter int BSR_LEN = 1524
) (
  // core domain
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_busy,
  input wire logic [BSR_LEN/3-1:0] core_out,
  input wire logic [BSR_LEN/3-1:0] core_oe,
  input wire logic [BSR_LEN/3-1:0] pin_out,
  input wire logic [BSR_LEN/3-1:0] pin_oe,
  input wire logic [BSR_LEN/3-1:0] pin_keep,
  input wire logic [BSP_CFG_BITS-1:0] cfg_data,
  input wire logic cfg_valid,
  // scan link
  input wire logic scan_clk,
  input wire logic tms,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // ----------------------------------------------------------
  // scan link
  // ----------------------------------------------------------
  // five ones reach reset from anywhere, then idle, select, capture
  sequence s_to_shift_dr;
    tms [*5] ##1 !tms ##1 tms ##1 !tms [*2];
  endsequence

  a_id_walk: assert property (@(posedge scan_clk) disable iff (rst)
    s_to_shift_dr |=> tdo_oe) else $error("shift state not entered");
  a_shift_stay: assert property (@(posedge scan_clk) disable iff (rst)
    tdo_oe && !tms |=> tdo_oe) else $error("shift left early");
  a_shift_exit: assert property (@(posedge scan_clk) disable iff (rst)
    tdo_oe && tms |=> !tdo_oe) else $error("shift not left");
  a_tdo_quiet: assert property (@(posedge scan_clk) disable iff (rst)
    !tdo_oe |-> !tdo) else $error("serial out busy outside shift");

  // ----------------------------------------------------------
  // core domain
  // ----------------------------------------------------------
  a_reset_quiet: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> pin_oe == '0 && !cfg_valid)
    else $error("outputs active after reset");
  a_cfg_pulse: assert property (@(posedge clk) disable iff (rst)
    cfg_valid |=> !cfg_valid) else $error("byte strobe too long");
  a_cfg_hold: assert property (@(posedge clk) disable iff (rst)
    !$stable(cfg_data) |-> cfg_valid) else $error("byte changed alone");
  a_keep_float: assert property (@(posedge clk) disable iff (rst)
    (pin_keep & pin_oe) == '0) else $error("keeper on a driven pin");
  a_busy_follow: assert property (@(posedge clk) disable iff (rst)
    cfg_busy [*3] |=> pin_out == $past(core_out) && pin_oe == $past(core_oe))
    else $error("pins not with core while configuring");
endmodule

bind bsp_test_port bsp_test_port_props #(.BSR_LEN(BSR_LEN)) u_props (
  .clk(clk), .rst(rst), .cfg_busy(cfg_busy), .core_out(core_out),
  .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_keep(pin_keep), .cfg_data(cfg_data), .cfg_valid(cfg_valid),
  .scan_clk(scan_clk), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe));

/* File: tb_top.sv */
// self-checking bench for the boundary-scan test port
module tb_top
  import bsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BSR = 12;
  localparam int N = BSR / 3;
  localparam int LA_W = 16;
  localparam logic [3:0] IDV = 4'h3; // arbitrary value
  localparam logic [15:0] IDP = 16'hA1E7; // arbitrary value
  localparam logic [10:0] IDM = 11'h1D2; // arbitrary value
  localparam logic [31:0] USR = 32'h3C5A96E1;
  logic clk = 1'b0;
  logic rst, scan_clk, tms, tdi, tdo, tdo_oe, cfg_busy, cfg_valid;
  logic la_done, hold_probe;
  logic [N-1:0] pin_in, core_out, core_oe, keep_en, pin_out, pin_oe;
  logic [N-1:0] pin_keep;
  logic [7:0] cfg_data;
  logic [15:0] probe, bytes;
  logic [63:0] d, din;
  logic [BSR-1:0] pat;
  logic [9:0] c;
  logic [9:0] byp [3];
  integer seed;
  int fails, cmp_count, cyc, nbytes;

  bsp_test_port #(.BSR_LEN(BSR), .LA_W(LA_W), .LA_DEPTH(8),
    .ID_VERSION(IDV), .ID_PART(IDP), .ID_MAKER(IDM), .USER_CODE(USR)) DUT (
    .clk(clk), .rst(rst), .scan_clk(scan_clk), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out),
    .core_oe(core_oe), .keep_en(keep_en), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_keep(pin_keep), .cfg_busy(cfg_busy),
    .cfg_data(cfg_data), .cfg_valid(cfg_valid), .probe(probe),
    .la_done(la_done));
  bsp_scan_host host (.scan_clk(scan_clk), .tms(tms), .tdi(tdi), .tdo(tdo));

  always #20 clk = ~clk;

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [63:0] e,
    input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic load_ir(input logic [9:0] code);
    logic [63:0] o;
    host.scan(1'b1, BSP_IR_LEN, 64'(code), o);
    chk("ir_capture", 64'(BSP_IR_CAPTURE), o);
  endtask

  function automatic logic [N-1:0] pick(logic [63:0] v, int off);
    for (int i = 0; i < N; i++) pick[i] = v[3*i+off];
  endfunction

  function automatic logic [BSR-1:0] img(logic [N-1:0] a, b, e);
    for (int i = 0; i < N; i++) img[3*i +: 3] = {e[i], b[i], a[i]};
  endfunction

  // byte strobe is read mid-cycle, away from the edge that moves it
  always @(negedge clk) begin
    if (cfg_valid === 1'b1) begin
      bytes = {cfg_data, bytes[15:8]};
      nbytes++;
    end
  end

  always @(posedge clk) begin
    probe <= #1 hold_probe ? probe : 16'($random(seed));
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  initial begin
    seed = 32'h6BC4;
    byp = '{BSP_INS_BYPASS, BSP_INS_HIGHZ, BSP_INS_CLAMP};
    rst = 1'b1;
    cfg_busy = 1'b0;
    hold_probe = 1'b0;
    {pin_in, core_out, core_oe, keep_en} = 16'($random(seed));
    // three scan edges reach the reset through its synchroniser
    fork
      host.run_tlr(3);
      step(12);
    join
    rst = 1'b0;
    host.run_tlr(5);
    chk("la_idle", 64'h0, 64'(la_done));
    host.scan(1'b0, 32, 64'($random(seed)), d);
    chk("ident", 64'({IDV, IDP, IDM, 1'b1}), d);
    load_ir(BSP_INS_USER);
    host.scan(1'b0, 32, 64'($random(seed)), d);
    chk("user", 64'(USR), d);
    load_ir(BSP_INS_SAMPLE);
    pat = BSR'($random(seed));
    host.scan(1'b0, BSR, 64'(pat), d);
    chk("sample", 64'(img(pin_in, core_out, core_oe)), d);
    load_ir(BSP_INS_EXTEST);
    step(10);
    chk("ext_out", 64'(pick(pat, 1)), 64'(pin_out));
    chk("ext_oe", 64'(pick(pat, 2)), 64'(pin_oe));
    chk("ext_keep", 64'(keep_en & ~pick(pat, 2)), 64'(pin_keep));
    host.scan(1'b0, BSR, 64'(pat), d);
    chk("ext_in", 64'(pin_in), 64'(pick(d, 0)));
    cfg_busy = 1'b1;
    step(5);
    chk("busy_out", 64'(core_out), 64'(pin_out));
    cfg_busy = 1'b0;
    load_ir(BSP_INS_HIGHZ);
    step(10);
    chk("hz_oe", 64'h0, 64'(pin_oe));
    chk("hz_keep", 64'(keep_en), 64'(pin_keep));
    load_ir(BSP_INS_CLAMP);
    step(10);
    chk("clamp_out", 64'(pick(pat, 1)), 64'(pin_out));
    chk("clamp_oe", 64'(pick(pat, 2)), 64'(pin_oe));
    for (int i = 0; i < 6; i++) begin
      c = (i < 3) ? byp[i] : (10'h100 | 10'($random(seed)));
      load_ir(c);
      din = 64'($random(seed));
      host.scan(1'b0, 8, din, d);
      chk("bypass", {56'h0, din[6:0], 1'b0}, d);
    end
    load_ir(BSP_INS_CFG_LOAD);
    din = 64'($random(seed));
    host.scan(1'b0, 16, din, d);
    step(10);
    chk("cfg_count", 64'h2, 64'(nbytes));
    chk("cfg_bytes", 64'(din[15:0]), 64'(bytes));
    // freeze the probe so every traced word is known
    hold_probe = 1'b1;
    load_ir(BSP_INS_LA_ARM);
    host.scan(1'b0, 1, 64'h0, d);
    step(20);
    chk("la_done", 64'h1, 64'(la_done));
    load_ir(BSP_INS_LA_READ);
    host.scan(1'b0, LA_W + 1, 64'h0, d);
    chk("la_read_done", 64'h1, 64'(d[LA_W]));
    chk("la_word", 64'(probe), 64'(d[LA_W-1:0]));
    give_verdict();
  end
endmodule
